//--- hw/sppc_pkg.sv
package sppc_pkg;
	// number of switch ports covered by the per-port control copies
	localparam int NPORT = 3;
	// register offsets
	localparam logic [7:0] OFF_UNK = 8'h0e;
	localparam logic [7:0] OFF_PHY = 8'h0f;
	localparam logic [7:0] OFF_P1 = 8'h10;
	localparam logic [7:0] OFF_P2 = 8'h20;
	localparam logic [7:0] OFF_P3 = 8'h30;
	// unknown destination control fields
	localparam int UNK_EN_BIT = 7;
	localparam int UNK_DRV_BIT = 6;
	localparam int UNK_MASK_LSB = 0;
	localparam int UNK_MASK_W = 3;
	localparam logic [7:0] UNK_RST = 8'h47;
	localparam logic [7:0] UNK_WMASK = 8'hc7;
	// transceiver address fields
	localparam int PHY_LSB = 3;
	localparam int PHY_W = 5;
	localparam logic [7:0] PHY_RST = 8'h08;
	localparam logic [7:0] PHY_WMASK = 8'hf8;
	localparam logic [4:0] PHY_BAD_LO = 5'h00;
	localparam logic [4:0] PHY_BAD_HI0 = 5'h1e;
	localparam logic [4:0] PHY_BAD_HI1 = 5'h1f;
	localparam logic [4:0] PHY_STEP = 5'h01;
	// per-port control fields
	localparam int PC_STORM = 7;
	localparam int PC_DS = 6;
	localparam int PC_TP = 5;
	localparam int PC_PRIO_LSB = 3;
	localparam int PRIO_W = 2;
	localparam int PC_TAG = 2;
	localparam logic [7:0] PC_RST = 8'h00;
	localparam logic [1:0] PORT_NONE = 2'h3;

	// map an offset onto a per-port copy, PORT_NONE when it is none
	function automatic logic [1:0] sppc_port_of(input logic [7:0] addr);
		logic [1:0] idx;
		idx = PORT_NONE;
		if (addr == OFF_P1) idx = 2'h0;
		if (addr == OFF_P2) idx = 2'h1;
		if (addr == OFF_P3) idx = 2'h2;
		return idx;
	endfunction
endpackage

//--- hw/sppc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// per-port control copies handed from the register bank to the classifier
interface sppc_cfg_if import sppc_pkg::*; ();
	logic [7:0] port_ctl [NPORT]; // one control byte per port
	modport src (output port_ctl);
	modport dst (input port_ctl);
endinterface
`default_nettype wire

//--- hw/sppc_classify.sv
`timescale 1ns/1ps
`default_nettype none
// ingress priority and egress tag decisions from the per-port controls
module sppc_classify import sppc_pkg::*; #(
	parameter int VID_W = 12
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	sppc_cfg_if.dst cfg,
	input wire logic cls_valid_in,
	input wire logic [1:0] cls_port_in,
	input wire logic ds_hit_in,
	input wire logic [PRIO_W-1:0] ds_prio_in,
	input wire logic tp_hit_in,
	input wire logic [PRIO_W-1:0] tp_prio_in,
	output logic [PRIO_W-1:0] prio_out,
	output logic prio_valid_out,
	input wire logic eg_valid_in,
	input wire logic [1:0] eg_port_in,
	input wire logic eg_tagged_in,
	input wire logic [VID_W-1:0] ing_vid_in,
	output logic tag_ins_out,
	output logic [VID_W-1:0] tag_vid_out,
	output logic tag_valid_out
);
	// ingress side selection
	wire cls_ok = cls_port_in < PORT_NONE; // port code 3 names no port
	wire [7:0] cls_ctl = cls_ok ? cfg.port_ctl[cls_port_in] : PC_RST;
	wire ds_use = cls_ctl[PC_DS] & ds_hit_in;
	wire tp_use = cls_ctl[PC_TP] & tp_hit_in;
	wire [PRIO_W-1:0] ds_part = ds_use ? ds_prio_in : '0;
	wire [PRIO_W-1:0] tp_part = tp_use ? tp_prio_in : '0;
	// both classifiers merge by or, port priority only as fallback
	wire [PRIO_W-1:0] prio_nxt = (ds_use | tp_use) ? (ds_part | tp_part) :
		cls_ctl[PC_PRIO_LSB+:PRIO_W];
	// egress side selection
	wire eg_ok = eg_port_in < PORT_NONE;
	wire [7:0] eg_ctl = eg_ok ? cfg.port_ctl[eg_port_in] : PC_RST;
	wire ins_nxt = eg_ctl[PC_TAG] & ~eg_tagged_in;

	// ingress result register, decisions use the live control copy
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prio_out <= '0;
			prio_valid_out <= 1'b0;
		end else if (ce_in) begin
			prio_out <= prio_nxt;
			prio_valid_out <= cls_valid_in & cls_ok;
		end
	end

	// egress result register
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tag_ins_out <= 1'b0;
			tag_vid_out <= '0;
			tag_valid_out <= 1'b0;
		end else if (ce_in) begin
			tag_ins_out <= ins_nxt;
			tag_vid_out <= ing_vid_in;
			tag_valid_out <= eg_valid_in & eg_ok;
		end
	end

	property p_prio_fallback;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && cls_valid_in && cls_ok && !ds_use && !tp_use)
		|=> (prio_out == $past(cls_ctl[4:3])) && prio_valid_out;
	endproperty
	a_prio_fallback: assert property (p_prio_fallback) else $error("fallback priority wrong");

	property p_prio_or;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && cls_valid_in && cls_ok && ds_use && tp_use)
		|=> prio_out == ($past(ds_prio_in) | $past(tp_prio_in));
	endproperty
	a_prio_or: assert property (p_prio_or) else $error("merged priority wrong");

	property p_ds_off;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && cls_valid_in && cls_ok && !cls_ctl[PC_DS] && !tp_use)
		|=> prio_out == $past(cls_ctl[4:3]);
	endproperty
	a_ds_off: assert property (p_ds_off) else $error("diffserv used while off");

	property p_tp_only;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && cls_valid_in && cls_ok && tp_use && !ds_use)
		|=> prio_out == $past(tp_prio_in);
	endproperty
	a_tp_only: assert property (p_tp_only) else $error("tag priority not used");

	property p_tag_ins;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && eg_valid_in && eg_ok)
		|=> tag_valid_out && (tag_ins_out == ($past(eg_ctl[2]) && !$past(eg_tagged_in)));
	endproperty
	a_tag_ins: assert property (p_tag_ins) else $error("tag insertion decision wrong");

	property p_tag_vid;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && eg_valid_in) |=> tag_vid_out == $past(ing_vid_in);
	endproperty
	a_tag_vid: assert property (p_tag_vid) else $error("inserted vid not ingress vid");

	c_prio_or: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		ce_in && cls_valid_in && ds_use && tp_use);
	c_tag_ins: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		ce_in && eg_valid_in && ins_nxt);
endmodule // sppc_classify
`default_nettype wire

//--- hw/sppc_top.sv
// Operation
// - mask bits pick ports for unknown destinations
// - mask applies only while forward enable set
// - forward enable resets to disabled
// - port1 transceiver address field, invalid codes refused
// - port2 transceiver answers at address plus one
// - three identical per-port control copies
// - bit 7 enables storm protection per port
// - bit 6 enables diffserv priority per port
// - bit 5 enables 802.1p priority per port
// - bits 4-3 give fallback port priority
// - enabled classifier results merge by or
// - bit 2 inserts tag on untagged frames
// - inserted tag carries ingress port vid
`timescale 1ns/1ps
`default_nettype none
module sppc_top import sppc_pkg::*; #(
	parameter int VID_W = 12
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic lk_valid_in,
	input wire logic lk_unknown_in,
	input wire logic [UNK_MASK_W-1:0] lk_mask_in,
	output logic [UNK_MASK_W-1:0] fwd_mask_out,
	output logic fwd_valid_out,
	input wire logic mii_valid_in,
	input wire logic [PHY_W-1:0] mii_addr_in,
	output logic [1:0] mii_sel_out,
	output logic [PHY_W-1:0] phy1_addr_out,
	output logic [PHY_W-1:0] phy2_addr_out,
	output logic drive_16ma_out,
	output logic [NPORT-1:0] storm_en_out,
	input wire logic cls_valid_in,
	input wire logic [1:0] cls_port_in,
	input wire logic ds_hit_in,
	input wire logic [PRIO_W-1:0] ds_prio_in,
	input wire logic tp_hit_in,
	input wire logic [PRIO_W-1:0] tp_prio_in,
	output logic [PRIO_W-1:0] prio_out,
	output logic prio_valid_out,
	input wire logic eg_valid_in,
	input wire logic [1:0] eg_port_in,
	input wire logic eg_tagged_in,
	input wire logic [VID_W-1:0] ing_vid_in,
	output logic tag_ins_out,
	output logic [VID_W-1:0] tag_vid_out,
	output logic tag_valid_out
);
	logic [7:0] unk_r; // unknown destination control
	logic [7:0] phy_r; // transceiver address select
	logic [7:0] port_ctl_r [NPORT]; // per-port control copies
	logic [PHY_W-1:0] phy2_r; // port2 address, kept as a flop
	logic [7:0] unk_nxt;
	logic [7:0] phy_nxt;
	logic [7:0] pc_nxt [NPORT];

	// address decode
	wire hit_unk = reg_addr_in == OFF_UNK;
	wire hit_phy = reg_addr_in == OFF_PHY;
	wire [1:0] pidx = sppc_port_of(reg_addr_in);
	wire hit_port = pidx != PORT_NONE;
	wire wr_unk = reg_wr_in & hit_unk;
	wire wr_phy = reg_wr_in & hit_phy;

	// reserved bits are forced back to their defaults on every write
	assign unk_nxt = wr_unk ? ((reg_wdata_in & UNK_WMASK) | (UNK_RST & ~UNK_WMASK)) : unk_r;
	wire [PHY_W-1:0] phy_code = reg_wdata_in[PHY_LSB+:PHY_W];
	// invalid codes are dropped so the address never leaves the legal range
	wire phy_ok = (phy_code != PHY_BAD_LO) && (phy_code != PHY_BAD_HI0) &&
		(phy_code != PHY_BAD_HI1);
	assign phy_nxt = (wr_phy && phy_ok) ?
		((reg_wdata_in & PHY_WMASK) | (PHY_RST & ~PHY_WMASK)) : phy_r;
	wire [PHY_W-1:0] phy2_nxt = phy_nxt[PHY_LSB+:PHY_W] + PHY_STEP;

	// per-port write steering, each copy only sees its own offset
	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_port
			assign pc_nxt[gi] = (reg_wr_in && pidx == 2'(gi)) ? reg_wdata_in :
				port_ctl_r[gi];
		end
	endgenerate

	// read selection, unmapped offsets read zero
	wire [7:0] rd_port = hit_port ? port_ctl_r[pidx] : 8'h00;
	wire [7:0] rd_mux = hit_unk ? unk_r : (hit_phy ? phy_r : rd_port);

	// forward decision: mask replaces normal ports only when enabled
	wire mask_on = lk_unknown_in & unk_r[UNK_EN_BIT];
	wire [UNK_MASK_W-1:0] fwd_nxt = mask_on ? unk_r[UNK_MASK_LSB+:UNK_MASK_W] : lk_mask_in;

	// management address match for both transceivers
	wire [1:0] sel_nxt = !mii_valid_in ? 2'h0 :
		(mii_addr_in == phy_r[PHY_LSB+:PHY_W]) ? 2'h1 :
		(mii_addr_in == phy2_r) ? 2'h2 : 2'h0;

	// storm enables gathered from each port copy
	logic [NPORT-1:0] storm_nxt;
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_storm
			assign storm_nxt[gi] = pc_nxt[gi][PC_STORM];
		end
	endgenerate

	// register bank
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			unk_r <= UNK_RST;
			phy_r <= PHY_RST;
			phy2_r <= PHY_RST[PHY_LSB+:PHY_W] + PHY_STEP;
			for (int i = 0; i < NPORT; i++) port_ctl_r[i] <= PC_RST;
		end else if (ce_in) begin
			unk_r <= unk_nxt;
			phy_r <= phy_nxt;
			phy2_r <= phy2_nxt;
			for (int i = 0; i < NPORT; i++) port_ctl_r[i] <= pc_nxt[i];
		end
	end

	// read answer, one cycle after the strobe
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else if (ce_in) begin
			reg_rdata_out <= reg_rd_in ? rd_mux : reg_rdata_out;
			reg_rvalid_out <= reg_rd_in;
		end
	end

	// frame-side and config outputs
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fwd_mask_out <= '0;
			fwd_valid_out <= 1'b0;
			mii_sel_out <= 2'h0;
			phy1_addr_out <= PHY_RST[PHY_LSB+:PHY_W];
			phy2_addr_out <= PHY_RST[PHY_LSB+:PHY_W] + PHY_STEP;
			drive_16ma_out <= UNK_RST[UNK_DRV_BIT];
			storm_en_out <= '0;
		end else if (ce_in) begin
			fwd_mask_out <= fwd_nxt;
			fwd_valid_out <= lk_valid_in;
			mii_sel_out <= sel_nxt;
			phy1_addr_out <= phy_nxt[PHY_LSB+:PHY_W];
			phy2_addr_out <= phy2_nxt;
			drive_16ma_out <= unk_nxt[UNK_DRV_BIT];
			storm_en_out <= storm_nxt;
		end
	end

	// control copies to the classifier; the host must have set global
	// 194 first or inserted tags are not usable downstream
	sppc_cfg_if cfg ();
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_cfg
			assign cfg.port_ctl[gi] = port_ctl_r[gi];
		end
	endgenerate

	sppc_classify #(.VID_W(VID_W)) u_cls (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.cfg(cfg),
		.cls_valid_in(cls_valid_in),
		.cls_port_in(cls_port_in),
		.ds_hit_in(ds_hit_in),
		.ds_prio_in(ds_prio_in),
		.tp_hit_in(tp_hit_in),
		.tp_prio_in(tp_prio_in),
		.prio_out(prio_out),
		.prio_valid_out(prio_valid_out),
		.eg_valid_in(eg_valid_in),
		.eg_port_in(eg_port_in),
		.eg_tagged_in(eg_tagged_in),
		.ing_vid_in(ing_vid_in),
		.tag_ins_out(tag_ins_out),
		.tag_vid_out(tag_vid_out),
		.tag_valid_out(tag_valid_out)
	);

	property p_mask_on;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && lk_valid_in && lk_unknown_in && unk_r[UNK_EN_BIT])
		|=> fwd_valid_out && (fwd_mask_out == $past(unk_r[2:0]));
	endproperty
	a_mask_on: assert property (p_mask_on) else $error("unknown mask not applied");

	property p_mask_off;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && lk_valid_in && !(lk_unknown_in && unk_r[UNK_EN_BIT]))
		|=> fwd_mask_out == $past(lk_mask_in);
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("mask used while disabled");

	property p_phy_bad;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && wr_phy && !phy_ok) |=> $stable(phy_r);
	endproperty
	a_phy_bad: assert property (p_phy_bad) else $error("invalid address code taken");

	property p_phy2;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		phy2_addr_out == 5'(phy1_addr_out + PHY_STEP);
	endproperty
	a_phy2: assert property (p_phy2) else $error("port2 address not plus one");

	property p_rsvd;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(unk_r[5:3] == 3'h0) && (phy_r[2:0] == 3'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits changed");

	property p_port_wr;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && reg_wr_in && hit_port) |=> port_ctl_r[$past(pidx)] == $past(reg_wdata_in);
	endproperty
	a_port_wr: assert property (p_port_wr) else $error("port copy not written");

	property p_read;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		(ce_in && reg_rd_in) |=> reg_rvalid_out && reg_rdata_out == $past(rd_mux);
	endproperty
	a_read: assert property (p_read) else $error("read answer wrong");

	c_mask: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		ce_in && lk_valid_in && mask_on);
	c_phy2: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		ce_in && sel_nxt == 2'h2);
	c_bad: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		ce_in && wr_phy && !phy_ok);
endmodule // sppc_top
`default_nettype wire

//--- tb/sppc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the register port: one strobe pulse per access
module sppc_host_model import sppc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out
);
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
	end
	// idle bus shows the inverse, so a stale value is never mistaken
	task automatic release_bus();
		reg_wr_out <= 1'b0;
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~reg_addr_out;
		reg_wdata_out <= ~reg_wdata_out;
	endtask
	// tag insertion setup is written by the test before any egress check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// reserved bits always written as their defaults
		if (a == OFF_UNK) v = d & UNK_WMASK;
		if (a == OFF_PHY) v = d & PHY_WMASK;
		@(posedge clk_sys_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= v;
		@(posedge clk_sys_in);
		release_bus();
	endtask
	// answer lands on the edge that takes the strobe, read just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk_sys_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge clk_sys_in);
		release_bus();
		#1;
		ok = reg_rvalid_in;
		d = reg_rdata_in;
	endtask
endmodule // sppc_host_model
`default_nettype wire

//--- tb/test_switch_port_priority_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_switch_port_priority_control;
	import sppc_pkg::*;
	logic clk_sys_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1;
	logic reg_wr_in, reg_rd_in, reg_rvalid_out, fwd_valid_out, drive_16ma_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic lk_valid_in = 1'b0, lk_unknown_in = 1'b0, mii_valid_in = 1'b0;
	logic [2:0] lk_mask_in = 3'h0;
	logic [2:0] fwd_mask_out, storm_en_out;
	logic [4:0] mii_addr_in = 5'h00;
	logic [4:0] phy1_addr_out, phy2_addr_out;
	logic [1:0] mii_sel_out, prio_out;
	logic cls_valid_in = 1'b0, ds_hit_in = 1'b0, tp_hit_in = 1'b0, prio_valid_out;
	logic [1:0] cls_port_in = 2'h0, ds_prio_in = 2'h0, tp_prio_in = 2'h0;
	logic eg_valid_in = 1'b0, eg_tagged_in = 1'b0, tag_ins_out, tag_valid_out;
	logic [1:0] eg_port_in = 2'h0;
	logic [11:0] ing_vid_in = 12'h000;
	logic [11:0] tag_vid_out;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	// far-side setup register for tag insertion, outside this block
	localparam logic [7:0] OFF_INS_SETUP = 8'hc2;
	// plain default: low six bits set
	localparam logic [7:0] INS_SETUP_VAL = 8'h3f;
	// 40 ns period
	always #20 clk_sys_in = ~clk_sys_in;
	sppc_host_model host_u (.clk_sys_in, .reg_rdata_in(reg_rdata_out),
		.reg_rvalid_in(reg_rvalid_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
	sppc_top #(.VID_W(12)) dut_u (.clk_sys_in, .resetn_in, .ce_in, .reg_wr_in, .reg_rd_in,
		.reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .lk_valid_in,
		.lk_unknown_in, .lk_mask_in, .fwd_mask_out, .fwd_valid_out, .mii_valid_in,
		.mii_addr_in, .mii_sel_out, .phy1_addr_out, .phy2_addr_out, .drive_16ma_out,
		.storm_en_out, .cls_valid_in, .cls_port_in, .ds_hit_in, .ds_prio_in, .tp_hit_in,
		.tp_prio_in, .prio_out, .prio_valid_out, .eg_valid_in, .eg_port_in, .eg_tagged_in,
		.ing_vid_in, .tag_ins_out, .tag_vid_out, .tag_valid_out);
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard: tests need under a hundred cycles
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		host_u.rd(a, d, ok);
		chk("rvalid", 12'h1, {11'h0, ok});
		chk("rdata", {4'h0, e}, {4'h0, d});
	endtask
	// each request is a one-cycle pulse, result read just after taking edge
	task automatic lookup(input logic u, input logic [2:0] m, input logic [2:0] e);
		@(posedge clk_sys_in);
		lk_valid_in <= 1'b1;
		lk_unknown_in <= u;
		lk_mask_in <= m;
		@(posedge clk_sys_in);
		lk_valid_in <= 1'b0;
		#1;
		chk("fwd_valid", 12'h1, {11'h0, fwd_valid_out});
		chk("fwd_mask", {9'h0, e}, {9'h0, fwd_mask_out});
	endtask
	task automatic mii(input logic [4:0] a, input logic [1:0] e);
		@(posedge clk_sys_in);
		mii_valid_in <= 1'b1;
		mii_addr_in <= a;
		@(posedge clk_sys_in);
		mii_valid_in <= 1'b0;
		#1;
		chk("mii_sel", {10'h0, e}, {10'h0, mii_sel_out});
	endtask
	task automatic cls(input logic [1:0] p, input logic [3:0] h, input logic [1:0] e);
		@(posedge clk_sys_in);
		cls_valid_in <= 1'b1;
		cls_port_in <= p;
		{ds_hit_in, ds_prio_in, tp_hit_in} <= h;
		tp_prio_in <= 2'h2;
		@(posedge clk_sys_in);
		cls_valid_in <= 1'b0;
		#1;
		chk("prio_valid", {11'h0, p != 2'h3}, {11'h0, prio_valid_out});
		if (p != 2'h3) chk("prio", {10'h0, e}, {10'h0, prio_out});
	endtask
	task automatic egr(input logic [1:0] p, input logic t, input logic e);
		@(posedge clk_sys_in);
		eg_valid_in <= 1'b1;
		eg_port_in <= p;
		eg_tagged_in <= t;
		ing_vid_in <= 12'h5a3 + p;
		@(posedge clk_sys_in);
		eg_valid_in <= 1'b0;
		#1;
		chk("tag_valid", {11'h0, p != 2'h3}, {11'h0, tag_valid_out});
		chk("tag_ins", {11'h0, e}, {11'h0, tag_ins_out});
		chk("tag_vid", 12'h5a3 + p, tag_vid_out);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		// defaults, unmapped offset reads zero
		rchk(OFF_UNK, 8'h47);
		rchk(OFF_PHY, 8'h08);
		rchk(8'h11, 8'h00);
		chk("phy1", 12'h1, {7'h0, phy1_addr_out});
		chk("phy2", 12'h2, {7'h0, phy2_addr_out});
		chk("drive", 12'h1, {11'h0, drive_16ma_out});
		lookup(1'b1, 3'h2, 3'h2);
		host_u.wr(OFF_UNK, 8'h85);
		lookup(1'b1, 3'h2, 3'h5);
		lookup(1'b0, 3'h2, 3'h2);
		rchk(OFF_UNK, 8'h85);
		chk("drive", 12'h0, {11'h0, drive_16ma_out});
		// invalid address codes dropped, valid one taken
		host_u.wr(OFF_PHY, 8'h00);
		host_u.wr(OFF_PHY, 8'hf0);
		rchk(OFF_PHY, 8'h08);
		host_u.wr(OFF_PHY, 8'h28);
		rchk(OFF_PHY, 8'h28);
		chk("phy1", 12'h5, {7'h0, phy1_addr_out});
		chk("phy2", 12'h6, {7'h0, phy2_addr_out});
		mii(5'h05, 2'h1);
		mii(5'h06, 2'h2);
		mii(5'h07, 2'h0);
		host_u.wr(OFF_P1, 8'h18);
		host_u.wr(OFF_P2, 8'h68);
		host_u.wr(OFF_P3, 8'h84);
		rchk(OFF_P2, 8'h68);
		chk("storm", 12'h4, {9'h0, storm_en_out});
		cls(2'h0, 4'hf, 2'h3);
		cls(2'h1, 4'hb, 2'h3);
		cls(2'h1, 4'h2, 2'h1);
		cls(2'h2, 4'hf, 2'h0);
		cls(2'h3, 4'hf, 2'h0);
		// diffserv gives 1, tag gives 2: a wrong source shows as 3
		host_u.wr(OFF_P2, 8'h48);
		cls(2'h1, 4'hb, 2'h1);
		host_u.wr(OFF_P2, 8'h28);
		cls(2'h1, 4'hb, 2'h2);
		// insertion setup on the far side before relying on tags
		host_u.wr(OFF_INS_SETUP, INS_SETUP_VAL);
		egr(2'h2, 1'b0, 1'b1);
		egr(2'h2, 1'b1, 1'b0);
		egr(2'h0, 1'b0, 1'b0);
		egr(2'h3, 1'b0, 1'b0);
		// frozen clock enable drops the write
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		host_u.wr(OFF_P1, 8'hff);
		@(posedge clk_sys_in);
		ce_in <= 1'b1;
		rchk(OFF_P1, 8'h18);
		// second reset in mid-run
		@(posedge clk_sys_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		rchk(OFF_P3, 8'h00);
		rchk(OFF_PHY, 8'h08);
		rchk(OFF_UNK, 8'h47);
		chk("storm", 12'h0, {9'h0, storm_en_out});
		chk("phy2", 12'h2, {7'h0, phy2_addr_out});
		chk("drive", 12'h1, {11'h0, drive_16ma_out});
		print_verdict();
	end
endmodule // test_switch_port_priority_control
`default_nettype wire
